// File: core/isa_bridge_pkg.sv
// constants, register map and types for the isa cycle bridge
package isa_bridge_pkg;
    // ==========================================
    // apb register offsets
    localparam logic [11:0] timing_ofs = 12'h000;
    localparam logic [11:0] clkdiv_ofs = 12'h004;
    localparam logic [11:0] status_ofs = 12'h008;
    // ==========================================
    // timing register fields
    localparam int cd_io_pos = 0;
    localparam int cd_m8_pos = 2;
    localparam int cd_m16_pos = 4;
    localparam int ws8_pos = 8;
    localparam int ws16_pos = 10;
    localparam int ahold_pos = 12;
    // ==========================================
    // reset values
    localparam logic [1:0] cd_io_rst = 2'h1;
    localparam logic [1:0] cd_m8_rst = 2'h1;
    localparam logic [1:0] cd_m16_rst = 2'h0;
    localparam logic [1:0] ws8_rst = 2'h2;
    localparam logic [1:0] ws16_rst = 2'h1;
    localparam logic ahold_rst = 1'b0;
    // half bus clock = clk_hz / (2 * 8 MHz), rounded up, for 200 MHz
    localparam int clk_mhz = 200;
    localparam int isa_mhz = 8;
    localparam logic [7:0] half_div_rst = 8'((clk_mhz + 2 * isa_mhz - 1) / (2 * isa_mhz));
    localparam logic [1:0] ws8_base = 2'h2;
    // ==========================================
    // cycle state machine
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_ale = 3'b001,
        st_cmd = 3'b011,
        st_end = 3'b010,
        st_hold = 3'b110
    } isa_state_t;
    // cycle destination
    typedef enum logic [2:0] {
        dst_none = 3'h0,
        dst_cache = 3'h1,
        dst_dram = 3'h2,
        dst_vl = 3'h3,
        dst_rom = 3'h4,
        dst_isa = 3'h5
    } dest_t;
endpackage

// File: core/isa_bus_cycle_bridge.sv
// local bus to isa bridge: claim priority, isa cycle timing and alternate master steering
`timescale 1ns/100ps
module isa_bus_cycle_bridge (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // local bus cycle
    input wire logic lb_start,
    input wire logic lb_mem,
    input wire logic lb_write,
    input wire logic lb_16bit,
    input wire logic lb_io_internal,
    input wire logic cache_hit,
    input wire logic dram_hit,
    input wire logic ldev_n,
    input wire logic rom_hit,
    input wire logic [7:0] lb_data_hi,
    output logic [2:0] dest,
    output logic lb_rdy,
    output logic boot_rom_select_n,
    output logic isa_data_block,
    // dram / peripheral shared lines
    input wire logic [7:0] dram_addr_in,
    input wire logic [7:0] mux_addr_in,
    output logic [7:0] dram_mux_addr_2_to_9,
    output logic dram_mux_addr_oe_n,
    output logic [7:0] periph_data_upper_byte,
    // isa bus
    input wire logic iochrdy,
    input wire logic zero_ws_n,
    input wire logic dma_master_grant_n,
    input wire logic alt_target_local,
    input wire logic alt_sbhe_n,
    input wire logic alt_a0,
    input wire logic alt_cmd_n,
    output logic isa_side_clock,
    output logic ale,
    output logic isa_cmd_n,
    output logic isa_cmd_oe_n,
    output logic byte_swap,
    output logic xd_buf_en_n,
    output logic xd_buf_dir,
    output logic lb_ctrl_oe_n,
    output logic lb_ads_n
);
    // ==========================================
    // state
    typedef struct packed {
        logic [1:0] cd_io;
        logic [1:0] cd_m8;
        logic [1:0] cd_m16;
        logic [1:0] ws8;
        logic [1:0] ws16;
        logic ahold;
        logic [7:0] half_div;
        logic [7:0] div_cnt;
        logic bclk;
        logic [2:0] rdy_s;
        logic [2:0] zws_s;
        logic [2:0] gnt_s;
        logic [2:0] acmd_s;
        isa_bridge_pkg::isa_state_t st;
        logic [3:0] half_cnt;
        logic [3:0] cmd_start;
        logic [3:0] cmd_end;
        logic is_io;
        logic is_8bit;
        logic cmd;
        isa_bridge_pkg::dest_t dst;
        logic rdy;
        logic [7:0] xd_hi;
        logic [31:0] rdata;
        logic busy;
    } state_t;
    state_t r_r, r_nxt;
    logic half_tick;
    logic [1:0] cd_sel;
    logic [3:0] ws_total;
    logic alt_active;
    // ==========================================
    // wait state count to half clocks
    function automatic logic [3:0] waits_to_half(input logic [3:0] w);
        waits_to_half = 4'((w + 4'h2) << 1);
    endfunction
    // ==========================================
    // register offset decode
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == isa_bridge_pkg::timing_ofs) || (a == isa_bridge_pkg::clkdiv_ofs) ||
            (a == isa_bridge_pkg::status_ofs);
    endfunction
    // ==========================================
    // next state
    always_comb begin
        r_nxt = r_r;
        half_tick = (r_r.div_cnt == 8'h00);
        alt_active = ~r_r.gnt_s[2];
        cd_sel = r_r.is_io ? r_r.cd_io : (r_r.is_8bit ? r_r.cd_m8 : r_r.cd_m16);
        if (r_r.is_8bit) begin
            ws_total = {2'h0, r_r.ws8} + {2'h0, isa_bridge_pkg::ws8_base};
        end else begin
            ws_total = {2'h0, r_r.ws16};
        end
        // ==========================================
        // synchronisers
        r_nxt.rdy_s = {r_r.rdy_s[1], r_r.rdy_s[0], iochrdy};
        r_nxt.zws_s = {r_r.zws_s[1], r_r.zws_s[0], zero_ws_n};
        r_nxt.gnt_s = {r_r.gnt_s[1], r_r.gnt_s[0], dma_master_grant_n};
        r_nxt.acmd_s = {r_r.acmd_s[1], r_r.acmd_s[0], alt_cmd_n};
        // ==========================================
        // isa clock divider
        if (half_tick) begin
            r_nxt.div_cnt = 8'(r_r.half_div - 8'h01);
            r_nxt.bclk = ~r_r.bclk;
        end else begin
            r_nxt.div_cnt = 8'(r_r.div_cnt - 8'h01);
        end
        r_nxt.rdy = 1'b0;
        // ==========================================
        // claim priority
        if (lb_start && !r_r.busy && !alt_active) begin
            r_nxt.busy = 1'b1;
            if (cache_hit) begin
                r_nxt.dst = isa_bridge_pkg::dst_cache;
            end else if (dram_hit && lb_mem) begin
                r_nxt.dst = isa_bridge_pkg::dst_dram;
            end else if (!ldev_n) begin
                r_nxt.dst = isa_bridge_pkg::dst_vl;
            end else if (rom_hit && lb_mem) begin
                r_nxt.dst = isa_bridge_pkg::dst_rom;
            end else begin
                r_nxt.dst = isa_bridge_pkg::dst_isa;
                r_nxt.is_io = ~lb_mem;
                r_nxt.is_8bit = ~lb_16bit;
            end
        end
        if (r_r.busy && r_r.dst != isa_bridge_pkg::dst_isa) begin
            r_nxt.busy = 1'b0;
            r_nxt.dst = isa_bridge_pkg::dst_none;
        end
        // ==========================================
        // isa cycle, counted in half bus clocks, one per bus clock edge
        case (r_r.st)
            isa_bridge_pkg::st_idle: begin
                if (r_r.busy && r_r.dst == isa_bridge_pkg::dst_isa && half_tick && !r_r.bclk) begin
                    r_nxt.st = isa_bridge_pkg::st_ale;
                    r_nxt.half_cnt = 4'h0;
                    if (lb_write) begin
                        r_nxt.xd_hi = lb_data_hi;
                    end
                end
            end
            isa_bridge_pkg::st_ale: begin
                if (half_tick) begin
                    r_nxt.st = isa_bridge_pkg::st_cmd;
                    r_nxt.half_cnt = 4'h1;
                    r_nxt.cmd_start = {2'h0, cd_sel};
                    r_nxt.cmd_end = waits_to_half(ws_total) - 4'h2;
                end
            end
            isa_bridge_pkg::st_cmd: begin
                r_nxt.cmd = (r_r.half_cnt >= r_r.cmd_start + 4'h1);
                if (half_tick) begin
                    if (!r_r.zws_s[2] && r_r.bclk) begin
                        r_nxt.st = isa_bridge_pkg::st_end;
                    end else if (r_r.half_cnt >= r_r.cmd_end) begin
                        if (r_r.rdy_s[2]) begin
                            r_nxt.st = isa_bridge_pkg::st_end;
                        end
                    end else begin
                        r_nxt.half_cnt = 4'(r_r.half_cnt + 4'h1);
                    end
                end
            end
            isa_bridge_pkg::st_end: begin
                r_nxt.cmd = 1'b0;
                if (r_r.ahold) begin
                    r_nxt.st = isa_bridge_pkg::st_hold;
                end else begin
                    r_nxt.st = isa_bridge_pkg::st_idle;
                    r_nxt.rdy = 1'b1;
                    r_nxt.busy = 1'b0;
                    r_nxt.dst = isa_bridge_pkg::dst_none;
                end
            end
            isa_bridge_pkg::st_hold: begin
                r_nxt.st = isa_bridge_pkg::st_idle;
                r_nxt.rdy = 1'b1;
                r_nxt.busy = 1'b0;
                r_nxt.dst = isa_bridge_pkg::dst_none;
            end
            default: begin
                r_nxt.st = isa_bridge_pkg::st_idle;
            end
        endcase
        if (r_r.st == isa_bridge_pkg::st_cmd && !lb_write && !lb_io_internal) begin
            r_nxt.xd_hi = mux_addr_in;
        end
        // ==========================================
        // apb
        r_nxt.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                isa_bridge_pkg::timing_ofs: begin
                    r_nxt.rdata = {19'h0, r_r.ahold, r_r.ws16, r_r.ws8, 2'h0, r_r.cd_m16, r_r.cd_m8, r_r.cd_io};
                end
                isa_bridge_pkg::clkdiv_ofs: begin
                    r_nxt.rdata = {24'h0, r_r.half_div};
                end
                isa_bridge_pkg::status_ofs: begin
                    r_nxt.rdata = {24'h0, alt_active, r_r.busy, r_r.dst, r_r.st};
                end
                default: begin
                    r_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == isa_bridge_pkg::timing_ofs) begin
                r_nxt.cd_io = pwdata[isa_bridge_pkg::cd_io_pos +: 2];
                r_nxt.cd_m8 = pwdata[isa_bridge_pkg::cd_m8_pos +: 2];
                r_nxt.cd_m16 = pwdata[isa_bridge_pkg::cd_m16_pos +: 2];
                r_nxt.ws8 = pwdata[isa_bridge_pkg::ws8_pos +: 2];
                r_nxt.ws16 = pwdata[isa_bridge_pkg::ws16_pos +: 2];
                r_nxt.ahold = pwdata[isa_bridge_pkg::ahold_pos];
            end else if (paddr == isa_bridge_pkg::clkdiv_ofs && pwdata[7:0] != 8'h00) begin
                r_nxt.half_div = pwdata[7:0];
            end
        end
    end
    // ==========================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '0;
            r_r.cd_io <= isa_bridge_pkg::cd_io_rst;
            r_r.cd_m8 <= isa_bridge_pkg::cd_m8_rst;
            r_r.cd_m16 <= isa_bridge_pkg::cd_m16_rst;
            r_r.ws8 <= isa_bridge_pkg::ws8_rst;
            r_r.ws16 <= isa_bridge_pkg::ws16_rst;
            r_r.ahold <= isa_bridge_pkg::ahold_rst;
            r_r.half_div <= isa_bridge_pkg::half_div_rst;
            r_r.rdy_s <= 3'h7;
            r_r.zws_s <= 3'h7;
            r_r.gnt_s <= 3'h7;
            r_r.acmd_s <= 3'h7;
        end else begin
            r_r <= r_nxt;
        end
    end
    // ==========================================
    // outputs
    always_comb begin
        // ==========================================
        // apb
        prdata = r_r.rdata;
        pready = 1'b1;
        pslverr = psel && penable && !is_mapped(paddr);
        // ==========================================
        // local bus
        dest = r_r.dst;
        lb_rdy = r_r.rdy;
        boot_rom_select_n = ~(r_r.dst == isa_bridge_pkg::dst_rom);
        isa_data_block = r_r.is_io && lb_io_internal && r_r.dst == isa_bridge_pkg::dst_isa;
        // ==========================================
        // isa bus
        isa_side_clock = r_r.bclk;
        ale = (r_r.st == isa_bridge_pkg::st_ale);
        isa_cmd_n = ~r_r.cmd;
        isa_cmd_oe_n = alt_active;
        // ==========================================
        // alternate master steering
        lb_ctrl_oe_n = ~alt_active;
        lb_ads_n = ~(alt_active && alt_target_local && !r_r.acmd_s[2]);
        byte_swap = alt_active && !alt_target_local && alt_a0 && !alt_sbhe_n;
        xd_buf_en_n = ~((alt_active && !r_r.acmd_s[2]) || r_r.st == isa_bridge_pkg::st_cmd);
        xd_buf_dir = alt_active ? alt_target_local : lb_write;
        // ==========================================
        // shared lines: peripheral byte during isa cycles, dram address otherwise
        dram_mux_addr_oe_n = 1'b0;
        dram_mux_addr_2_to_9 = (r_r.st != isa_bridge_pkg::st_idle) ? r_r.xd_hi : dram_addr_in;
        periph_data_upper_byte = r_r.xd_hi;
    end
endmodule

// File: tb/isa_bridge_monitor.sv
// port checker for the isa cycle bridge
`timescale 1ns/100ps
module isa_bridge_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // local bus
    input wire logic lb_start,
    input wire logic cache_hit,
    input wire logic dram_hit,
    input wire logic ldev_n,
    input wire logic rom_hit,
    input wire logic lb_rdy,
    input wire logic boot_rom_select_n,
    input wire logic [2:0] dest,
    // isa and shared lines
    input wire logic dma_master_grant_n,
    input wire logic isa_cmd_n,
    input wire logic isa_cmd_oe_n,
    input wire logic lb_ctrl_oe_n,
    input wire logic [7:0] dram_mux_addr_2_to_9,
    input wire logic [7:0] periph_data_upper_byte
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // steps of a cycle
    sequence s_take;
        lb_start && dest == 3'h0 && dma_master_grant_n && $past(dma_master_grant_n, 4);
    endsequence
    sequence s_isa_cmd;
        !isa_cmd_n && !isa_cmd_oe_n;
    endsequence
    sequence s_cmd_end;
        $rose(isa_cmd_n) && !isa_cmd_oe_n;
    endsequence
    // ==========================================
    // assertions
    AST_PRIO_CACHE: assert property (s_take ##0 cache_hit |=> dest == 3'h1)
        else $error("cache claim lost");
    AST_PRIO_DRAM: assert property (s_take ##0 (!cache_hit && dram_hit) |=> dest == 3'h2)
        else $error("dram claim lost");
    AST_PRIO_VL: assert property (s_take ##0 (!cache_hit && !dram_hit && !ldev_n) |=> dest == 3'h3)
        else $error("vl claim lost");
    AST_PRIO_ROM: assert property (s_take ##0 (!cache_hit && !dram_hit && ldev_n && rom_hit)
        |=> dest == 3'h4 && !boot_rom_select_n)
        else $error("rom claim lost");
    AST_DEFAULT_ISA: assert property (s_take ##0 (!cache_hit && !dram_hit && ldev_n && !rom_hit)
        |=> dest == 3'h5)
        else $error("unclaimed cycle not sent to isa");
    AST_CMD_ONLY_ISA: assert property (s_isa_cmd |-> dest == 3'h5)
        else $error("command without isa cycle");
    AST_SHARED_LINES: assert property (s_isa_cmd |-> dram_mux_addr_2_to_9 == periph_data_upper_byte)
        else $error("shared lines not carrying peripheral byte");
    AST_GRANT_FLOAT: assert property ((!dma_master_grant_n) [*5] |-> isa_cmd_oe_n && !lb_ctrl_oe_n)
        else $error("grant not floating commands");
    AST_READY_AFTER_CMD: assert property (s_cmd_end |-> ##[0:1] lb_rdy)
        else $error("ready late after command end");
    AST_RDY_SINGLE: assert property (lb_rdy |=> !lb_rdy)
        else $error("ready longer than one cycle");
endmodule
bind isa_bus_cycle_bridge isa_bridge_monitor u_isa_bridge_monitor (.*);

// File: tb/isa_slave_model.sv
// isa slave model: stretches or shortens cycles on command
`timescale 1ns/100ps
module isa_slave_model (
    // clock and command
    input wire logic pclk,
    input wire logic isa_cmd_n,
    input wire logic [1:0] mode,
    // active-low replies, driven high when idle
    output logic iochrdy,
    output logic zero_ws_n
);
    int n = 0;
    initial begin
        iochrdy = 1'b1;
        zero_ws_n = 1'b1;
    end
    always @(posedge pclk) begin
        iochrdy <= !(!isa_cmd_n && mode == 2'h1 && n < 20);
        zero_ws_n <= !(!isa_cmd_n && mode == 2'h2);
        n <= isa_cmd_n ? 0 : n + 1;
    end
endmodule

// File: tb/tb_top.sv
// testbench for the isa cycle bridge
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    localparam int half = 2;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lb_start = 0;
    logic lb_mem = 1, lb_write = 0, lb_16bit = 0, lb_io_internal = 0;
    logic cache_hit = 0, dram_hit = 0, ldev_n = 1, rom_hit = 0, dma_master_grant_n = 1;
    logic alt_target_local = 0, alt_sbhe_n = 1, alt_a0 = 0, alt_cmd_n = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] lb_data_hi = 8'h5a, dram_addr_in = 8'h3c, mux_addr_in = 8'hc3;
    logic [7:0] dram_mux_addr_2_to_9, periph_data_upper_byte;
    logic [2:0] dest;
    logic [1:0] mode = 0;
    logic pready, pslverr, lb_rdy, boot_rom_select_n, isa_data_block, dram_mux_addr_oe_n, iochrdy;
    logic zero_ws_n, isa_side_clock, ale, isa_cmd_n, isa_cmd_oe_n, byte_swap, xd_buf_en_n;
    logic xd_buf_dir, lb_ctrl_oe_n, lb_ads_n, err, blk, v;
    int n_fail = 0, comparisons = 0, w, h, h0, n, al;
    always #2.5 pclk = ~pclk;
    isa_bus_cycle_bridge u_isa_bus_cycle_bridge (.*);
    isa_slave_model u_isa_slave_model (.pclk(pclk), .isa_cmd_n(isa_cmd_n), .mode(mode),
        .iochrdy(iochrdy), .zero_ws_n(zero_ws_n));
    // ==========================================
    // shared tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cyc(input logic [3:0] hit, input logic [3:0] at, input logic [2:0] ed);
        {cache_hit, dram_hit, ldev_n, rom_hit} <= hit;
        {lb_mem, lb_write, lb_16bit, lb_io_internal} <= at;
        lb_start <= 1'b1;
        @(posedge pclk);
        lb_start <= 1'b0;
        @(negedge pclk);
        `CHK(dest, ed)
        `CHK(boot_rom_select_n, ed != 3'h4)
        w = 0;
        h = 0;
        al = 0;
        blk = 0;
        while (!(lb_rdy === 1'b1 || (ed != 3'h5 && dest === 3'h0))) begin
            if (ale === 1'b1) al++;
            if (isa_cmd_n === 1'b0) w++;
            else if (w > 0) h++;
            if (isa_data_block === 1'b1) blk = 1'b1;
            @(negedge pclk);
        end
        @(posedge pclk);
    endtask
    function automatic int ew(int cd, int ws);
        return (2 * ws + 2 - cd) * half;
    endfunction
    // ==========================================
    // scenarios
    task t_regs;
        apb(0, isa_bridge_pkg::timing_ofs, 0);
        `CHK(rd, 32'h00000605)
        apb(0, isa_bridge_pkg::clkdiv_ofs, 0);
        `CHK(rd[7:0], isa_bridge_pkg::half_div_rst)
        apb(1, isa_bridge_pkg::clkdiv_ofs, half);
        apb(1, isa_bridge_pkg::clkdiv_ofs, 0);
        apb(0, isa_bridge_pkg::clkdiv_ofs, 0);
        `CHK(rd, 32'(half))
        apb(0, 12'h00c, 0);
        `CHK(err, 1'b1)
        @(negedge pclk);
        v = isa_side_clock;
        while (isa_side_clock === v) @(negedge pclk);
        n = 0;
        v = isa_side_clock;
        while (isa_side_clock === v) begin
            n++;
            @(negedge pclk);
        end
        @(posedge pclk);
        `CHK(n, half)
    endtask
    task t_claim;
        logic [3:0] hp[5] = '{4'b1101, 4'b0101, 4'b0001, 4'b0011, 4'b0010};
        for (int i = 0; i < 5; i++) cyc(hp[i], 4'b1000, 3'(i + 1));
        cyc(4'b0010, 4'b0001, 3'h5);
        `CHK(blk, 1'b1)
        cyc(4'b0010, 4'b0000, 3'h5);
        `CHK(blk, 1'b0)
        @(negedge pclk);
        `CHK(dram_mux_addr_2_to_9, dram_addr_in)
        `CHK(dram_mux_addr_oe_n, 1'b0)
        `CHK(periph_data_upper_byte, mux_addr_in)
        @(posedge pclk);
    endtask
    task t_timing;
        int c8[3] = '{1, 3, 0}, w8[3] = '{4, 2, 5}, c16[3] = '{0, 0, 2}, w16[3] = '{1, 0, 3};
        for (int i = 0; i < 3; i++) begin
            apb(1, isa_bridge_pkg::timing_ofs, 32'(1 + (c8[i] << 2) + (c16[i] << 4) + ((w8[i] - 2) << 8)
                + (w16[i] << 10)));
            cyc(4'b0010, 4'b1000, 3'h5);
            `CHK(w, ew(c8[i], w8[i]))
            `CHK(al, half)
            cyc(4'b0010, 4'b1010, 3'h5);
            `CHK(w, ew(c16[i], w16[i]))
        end
    endtask
    task t_hold;
        apb(1, isa_bridge_pkg::timing_ofs, 32'h00000605);
        cyc(4'b0010, 4'b1000, 3'h5);
        h0 = h;
        apb(1, isa_bridge_pkg::timing_ofs, 32'h00001605);
        cyc(4'b0010, 4'b1000, 3'h5);
        `CHK(h, h0 + 1)
        apb(1, isa_bridge_pkg::timing_ofs, 32'h00000605);
    endtask
    task t_slave;
        mode <= 2'h1;
        cyc(4'b0010, 4'b1000, 3'h5);
        `CHK(w > ew(1, 4), 1'b1)
        mode <= 2'h2;
        cyc(4'b0010, 4'b1000, 3'h5);
        `CHK(w < ew(1, 4), 1'b1)
        mode <= 2'h0;
    endtask
    task t_grant;
        dma_master_grant_n <= 1'b0;
        alt_cmd_n <= 1'b0;
        alt_target_local <= 1'b1;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        `CHK(isa_cmd_oe_n, 1'b1)
        `CHK(lb_ctrl_oe_n, 1'b0)
        `CHK(lb_ads_n, 1'b0)
        `CHK(xd_buf_dir, 1'b1)
        `CHK(xd_buf_en_n, 1'b0)
        @(posedge pclk);
        alt_target_local <= 1'b0;
        alt_a0 <= 1'b1;
        alt_sbhe_n <= 1'b0;
        @(negedge pclk);
        `CHK(byte_swap, 1'b1)
        `CHK(lb_ads_n, 1'b1)
        @(posedge pclk);
        dma_master_grant_n <= 1'b1;
        alt_cmd_n <= 1'b1;
        alt_a0 <= 1'b0;
        alt_sbhe_n <= 1'b1;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        `CHK(isa_cmd_oe_n, 1'b0)
        `CHK(lb_ctrl_oe_n, 1'b1)
        `CHK(byte_swap, 1'b0)
    endtask
    task final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_claim();
        t_timing();
        t_hold();
        t_slave();
        t_grant();
        final_report();
    end
    initial begin
        #300000;
        n_fail++;
        final_report();
    end
endmodule
